/* cpcf_top.sv */
// point compare flags of counter channel one with avalon-mm register slave
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "cpcf_regs.svh"

module cpcf_top
  import cpcf_pkg::*;
#(
  parameter int HOLD_CYCLES = `CPCF_HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] counterValue,
  input wire logic scanEnd,
  input wire logic zphasePresetReq,
  output logic matchOut1,
  output logic matchOut2,
  output logic irq
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

  cpcf_bus_state_t busState_q;
  cpcf_ctrl_t ctrl_q;
  cpcf_flags_t flags;
  logic [31:0] point_q [0:1];
  logic [31:0] readData_q;
  logic [31:0] rdMux;
  logic [4:0] irqStat_q;
  logic [4:0] irqStat_d;
  logic [4:0] irqMask_q;
  logic [4:0] events;
  logic irq_q;
  logic irqLevel;
  logic wrEn;
  logic rdCap;
  logic [1:0] greaterV;
  logic [1:0] smallerV;
  logic [1:0] matchV;
  logic [1:0] matchRise;
  logic [1:0] shortRel;
  logic [1:0] resetCmd;
  logic [1:0] matchOut_q;
  logic zPend_q;
  logic zDet_q;
  logic zDet_d;
  logic zSet;

  // avalon slave: one wait cycle, data latched before release
  assign avs_waitrequest = (avs_read | avs_write) & (busState_q == BUS_IDLE);
  assign wrEn = avs_write & (busState_q == BUS_ACK);
  assign rdCap = avs_read & (busState_q == BUS_IDLE);

  // one wait state, then back to idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busState_q <= BUS_IDLE;
    end else begin
      case (busState_q)
        BUS_IDLE: begin
          if (avs_read | avs_write) begin
            busState_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // control register; commands are levels held by software
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `CPCF_RST_CTRL;
    end else if (wrEn && avs_address == `CPCF_OFS_CTRL && avs_byteenable[0]) begin
      ctrl_q <= avs_writedata[3:0];
    end
  end

  assign resetCmd[0] = ctrl_q.pt1MatchResetCmd;
  assign resetCmd[1] = ctrl_q.pt2MatchResetCmd;

  // coincidence points, byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      point_q[0] <= `CPCF_RST_POINT;
      point_q[1] <= `CPCF_RST_POINT;
    end else if (wrEn) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          if (avs_address == `CPCF_OFS_POINT1) begin
            point_q[0][8*b +: 8] <= avs_writedata[8*b +: 8];
          end
          if (avs_address == `CPCF_OFS_POINT2) begin
            point_q[1][8*b +: 8] <= avs_writedata[8*b +: 8];
          end
        end
      end
    end
  end

  // per-point compare, match and reset hold check
  for (genvar i = 0; i < 2; i++) begin : gPoint
    logic gt;
    logic eq;
    logic lt;
    logic greater_q;
    logic smaller_q;
    logic match_q;
    logic match_d;
    logic resetPrev_q;
    logic [HOLD_W-1:0] holdCnt_q;
    logic out_q;

    // counter and points are two's complement values
    assign gt = $signed(counterValue) > $signed(point_q[i]);
    // equality needs no sign: equal bits are equal values
    assign eq = counterValue == point_q[i];
    assign lt = $signed(counterValue) < $signed(point_q[i]);

    // RULE_01 RULE_05 RULE_11 greater at scan end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        greater_q <= 1'b0;
      end else if (scanEnd) begin
        greater_q <= gt;
      end
    end

    // RULE_04 RULE_08 RULE_11 smaller at scan end
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        smaller_q <= 1'b0;
      end else if (scanEnd) begin
        smaller_q <= lt;
      end
    end

    // RULE_02 RULE_06 RULE_11 immediate set
    // RULE_03 RULE_07 RULE_12 held reset clears
    always_comb begin
      match_d = match_q;
      if (eq) begin
        match_d = 1'b1;
      end else if (resetCmd[i]) begin
        match_d = 1'b0;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        match_q <= 1'b0;
      end else begin
        match_q <= match_d;
      end
    end

    // release before the hold time is only reported
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        resetPrev_q <= 1'b0;
      end else begin
        resetPrev_q <= resetCmd[i];
      end
    end

    // saturating count, so a long hold cannot wrap into a false short release
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        holdCnt_q <= '0;
      end else if (!resetCmd[i]) begin
        holdCnt_q <= '0;
      end else if (holdCnt_q < HOLD_W'(HOLD_CYCLES)) begin
        holdCnt_q <= holdCnt_q + 1'b1;
      end
    end

    // RULE_13 gated outputs
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        out_q <= 1'b0;
      end else begin
        out_q <= match_q & ctrl_q.matchOutputEnableCmd;
      end
    end

    assign greaterV[i] = greater_q;
    assign smallerV[i] = smaller_q;
    assign matchV[i] = match_q;
    assign matchRise[i] = match_d & ~match_q;
    assign shortRel[i] = resetPrev_q & ~resetCmd[i] & (holdCnt_q < HOLD_W'(HOLD_CYCLES));
    assign matchOut_q[i] = out_q;
  end

  // request caught at once so a short pulse between scans is kept
  // RULE_09 capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zPend_q <= 1'b0;
    end else if (zphasePresetReq) begin
      zPend_q <= 1'b1;
    end else if (scanEnd) begin
      zPend_q <= 1'b0;
    end
  end

  // a request in the scan-end cycle itself still counts
  assign zSet = scanEnd & (zPend_q | zphasePresetReq);

  // RULE_10 RULE_11 set at scan end wins over clear
  always_comb begin
    zDet_d = zDet_q;
    if (zSet) begin
      zDet_d = 1'b1;
    end else if (ctrl_q.zphaseClearCmd) begin
      zDet_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zDet_q <= 1'b0;
    end else begin
      zDet_q <= zDet_d;
    end
  end

  // flags word in the layout software reads
  always_comb begin
    flags.pt1GreaterFlag = greaterV[0];
    flags.pt1MatchFlag = matchV[0];
    flags.pt1SmallerFlag = smallerV[0];
    flags.pt2GreaterFlag = greaterV[1];
    flags.pt2MatchFlag = matchV[1];
    flags.pt2SmallerFlag = smallerV[1];
    flags.zphasePresetDetected = zDet_q;
  end

  // interrupt events: new match, new phase-Z detection, short reset
  always_comb begin
    events = 5'h00;
    events[`CPCF_IRQ_PT1_MATCH] = matchRise[0];
    events[`CPCF_IRQ_PT2_MATCH] = matchRise[1];
    events[`CPCF_IRQ_Z_DET] = zDet_d & ~zDet_q;
    events[`CPCF_IRQ_PT1_SHORT] = shortRel[0];
    events[`CPCF_IRQ_PT2_SHORT] = shortRel[1];
  end

  // write one to clear; a same-cycle event stays set
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrEn && avs_address == `CPCF_OFS_IRQ_STAT && avs_byteenable[0]) begin
      irqStat_d = irqStat_q & ~avs_writedata[4:0];
    end
    irqStat_d = irqStat_d | events;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStat_q <= `CPCF_RST_IRQ;
    end else begin
      irqStat_q <= irqStat_d;
    end
  end

  // mask, same layout as status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqMask_q <= `CPCF_RST_IRQ;
    end else if (wrEn && avs_address == `CPCF_OFS_IRQ_MASK && avs_byteenable[0]) begin
      irqMask_q <= avs_writedata[4:0];
    end
  end

  assign irqLevel = |(irqStat_q & irqMask_q);

  // registered, so the line follows status by one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irqLevel;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h00000000;
    case (avs_address)
      `CPCF_OFS_CTRL: begin
        rdMux[3:0] = ctrl_q;
      end
      `CPCF_OFS_POINT1: begin
        rdMux = point_q[0];
      end
      `CPCF_OFS_POINT2: begin
        rdMux = point_q[1];
      end
      `CPCF_OFS_FLAGS: begin
        rdMux[6:0] = flags;
      end
      `CPCF_OFS_COUNT: begin
        rdMux = counterValue;
      end
      `CPCF_OFS_IRQ_STAT: begin
        rdMux[4:0] = irqStat_q;
      end
      `CPCF_OFS_IRQ_MASK: begin
        rdMux[4:0] = irqMask_q;
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readData_q <= 32'h00000000;
    end else if (rdCap) begin
      readData_q <= rdMux;
    end
  end

  // outputs come straight from flip-flops
  assign avs_readdata = readData_q;
  assign matchOut1 = matchOut_q[0];
  assign matchOut2 = matchOut_q[1];
  assign irq = irq_q;

endmodule : cpcf_top
`default_nettype wire

/* cpcf_regs.svh */
// register offsets, field positions, reset values and timing counts of the point compare flags
// Summary of operation
// RULE_01: point-one greater flag high while counter above point one, low otherwise.
// RULE_02: point-one match flag sets when counter equals point one.
// RULE_03: point-one match flag stays set until point-one match reset command.
// RULE_04: point-one smaller flag high while counter below point one, low otherwise.
// RULE_05: point-two greater flag high while counter above point two, low otherwise.
// RULE_06: point-two match flag sets when counter equals point two.
// RULE_07: point-two match flag stays set until point-two match reset command.
// RULE_08: point-two smaller flag high while counter below point two, low otherwise.
// RULE_09: phase-Z detected flag sets when a preset request arrives on phase-Z input.
// RULE_10: phase-Z detected flag stays set until the detection clear command.
// RULE_11: greater, smaller, phase-Z flags refresh at scan end; match flags immediately too.
// RULE_12: program holds each match reset at least 2 ms; reset acts while held.
// RULE_13: coincidence outputs driven only while output enable command is held.
`ifndef CPCF_REGS_SVH
`define CPCF_REGS_SVH

`define CPCF_OFS_CTRL 8'h00
`define CPCF_OFS_POINT1 8'h04
`define CPCF_OFS_POINT2 8'h08
`define CPCF_OFS_FLAGS 8'h0c
`define CPCF_OFS_COUNT 8'h10
`define CPCF_OFS_IRQ_STAT 8'h14
`define CPCF_OFS_IRQ_MASK 8'h18

`define CPCF_CTRL_PT1_RST 0
`define CPCF_CTRL_PT2_RST 1
`define CPCF_CTRL_OUT_EN 2
`define CPCF_CTRL_Z_CLR 3

`define CPCF_IRQ_PT1_MATCH 0
`define CPCF_IRQ_PT2_MATCH 1
`define CPCF_IRQ_Z_DET 2
`define CPCF_IRQ_PT1_SHORT 3
`define CPCF_IRQ_PT2_SHORT 4

`define CPCF_RST_CTRL 4'h0
`define CPCF_RST_POINT 32'h00000000
`define CPCF_RST_IRQ 5'h00

`define CPCF_CLK_KHZ 20000
`define CPCF_HOLD_TIME_MS 2
`define CPCF_HOLD_CYCLES (`CPCF_HOLD_TIME_MS * `CPCF_CLK_KHZ)

`endif

/* cpcf_pkg.sv */
// types shared by the point compare flags block
package cpcf_pkg;

  typedef struct packed {
    logic zphasePresetDetected;
    logic pt2SmallerFlag;
    logic pt2MatchFlag;
    logic pt2GreaterFlag;
    logic pt1SmallerFlag;
    logic pt1MatchFlag;
    logic pt1GreaterFlag;
  } cpcf_flags_t;

  typedef struct packed {
    logic zphaseClearCmd;
    logic matchOutputEnableCmd;
    logic pt2MatchResetCmd;
    logic pt1MatchResetCmd;
  } cpcf_ctrl_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } cpcf_bus_state_t;

endpackage : cpcf_pkg

/* cpcf_top_unused_guard.sv */
// empty source; no logic of the block lives here
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* cpcf_chk_sva.sv */
// assertions on the point compare flags ports
`timescale 1ns/1ns
`default_nettype none
`include "cpcf_regs.svh"
module cpcf_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] counterValue,
  input wire logic scanEnd,
  input wire logic matchOut1,
  input wire logic matchOut2
);
  logic [31:0] pt1_q, pt2_q;
  logic [3:0] ctrl_q, cmp_q;
  logic rdOk;
  assign rdOk = avs_read && !avs_waitrequest;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // mirror of software writes, byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {pt1_q, pt2_q, ctrl_q} <= '0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == `CPCF_OFS_CTRL && avs_byteenable[0]) begin
        ctrl_q <= avs_writedata[3:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b] && avs_address == `CPCF_OFS_POINT1) begin
          pt1_q[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
        if (avs_byteenable[b] && avs_address == `CPCF_OFS_POINT2) begin
          pt2_q[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end
    end
  end
  // compare outcome held from the last scan end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp_q <= 4'h0;
    end else if (scanEnd) begin
      cmp_q <= {$signed(counterValue) < $signed(pt2_q), $signed(counterValue) > $signed(pt2_q),
        $signed(counterValue) < $signed(pt1_q), $signed(counterValue) > $signed(pt1_q)};
    end
  end
  property p_cmp;
    rdOk && avs_address == `CPCF_OFS_FLAGS |->
      {avs_readdata[5], avs_readdata[3:2], avs_readdata[0]} == $past(cmp_q);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  property p_set1; counterValue == pt1_q ##1 ctrl_q[2] |=> matchOut1; endproperty
  a_set1: assert property (p_set1) else $error("point one match missed");
  property p_set2; counterValue == pt2_q ##1 ctrl_q[2] |=> matchOut2; endproperty
  a_set2: assert property (p_set2) else $error("point two match missed");
  property p_hold1; matchOut1 && ctrl_q[2] && !$past(ctrl_q[0]) |=> matchOut1; endproperty
  a_hold1: assert property (p_hold1) else $error("point one match dropped");
  property p_hold2; matchOut2 && ctrl_q[2] && !$past(ctrl_q[1]) |=> matchOut2; endproperty
  a_hold2: assert property (p_hold2) else $error("point two match dropped");
  property p_clr1; ctrl_q[0] && counterValue != pt1_q |-> ##2 !matchOut1; endproperty
  a_clr1: assert property (p_clr1) else $error("point one reset ignored");
  property p_clr2; ctrl_q[1] && counterValue != pt2_q |-> ##2 !matchOut2; endproperty
  a_clr2: assert property (p_clr2) else $error("point two reset ignored");
  property p_en; !ctrl_q[2] |=> !matchOut1 && !matchOut2; endproperty
  a_en: assert property (p_en) else $error("output without enable");
  c_m1: cover property (matchOut1);
  c_m2: cover property (matchOut2);
  c_clr: cover property (ctrl_q[0] ##1 !ctrl_q[0]);
endmodule : cpcf_chk
bind cpcf_top cpcf_chk u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .counterValue(counterValue),
  .scanEnd(scanEnd),
  .matchOut1(matchOut1),
  .matchOut2(matchOut2)
);
`default_nettype wire

/* cpcf_encoder_model.sv */
// pulse encoder model feeding counter channel one
`timescale 1ns/1ns
`default_nettype none
module cpcf_encoder_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] goal,
  input wire logic zReq,
  output logic [31:0] counterValue,
  output logic scanEnd,
  output logic zphasePresetReq
);
  logic [2:0] scan_q;
  // one step a cycle, so every value on the way is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counterValue <= 32'h0;
    end else if ($signed(counterValue) < $signed(goal)) begin
      counterValue <= counterValue + 32'h1;
    end else if ($signed(counterValue) > $signed(goal)) begin
      counterValue <= counterValue - 32'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    scan_q <= rst ? 3'h0 : scan_q + 3'h1;
    scanEnd <= !rst && scan_q == 3'h7;
    zphasePresetReq <= !rst && zReq;
  end
endmodule : cpcf_encoder_model
`default_nettype wire

/* counter_point_compare_flags_tb_top.sv */
// testbench of the point compare flags block
`timescale 1ns/1ns
`default_nettype none
module counter_point_compare_flags_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic zReq = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] goal = 32'h0;
  logic [31:0] avs_readdata, counterValue, rdata;
  logic avs_waitrequest, matchOut1, matchOut2, irq, scanEnd, zphasePresetReq;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 sys_clk = ~sys_clk;
  cpcf_top #(.HOLD_CYCLES(8)) u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .counterValue(counterValue), .scanEnd(scanEnd), .zphasePresetReq(zphasePresetReq),
    .matchOut1(matchOut1), .matchOut2(matchOut2), .irq(irq));
  cpcf_encoder_model u_enc (.sys_clk(sys_clk), .rst(rst), .goal(goal), .zReq(zReq),
    .counterValue(counterValue), .scanEnd(scanEnd), .zphasePresetReq(zphasePresetReq));
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
    chk(rdata, exp);
  endtask : rd
  // a hung handshake ends the run here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h04, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'hfffffffd);
    // reset held past the hold count
    wr(8'h00, 32'h3);
    repeat (10) @(posedge sys_clk);
    wr(8'h00, 32'h4);
    wr(8'h14, 32'h1f);
    rd(8'h0c, 32'h0c);
    wr(8'h18, 32'h7);
    goal <= 32'ha;
    repeat (30) @(posedge sys_clk);
    rd(8'h0c, 32'h0b);
    chk({31'h0, irq}, 32'h1);
    rd(8'h14, 32'h1);
    goal <= 32'hfffffffa;
    repeat (40) @(posedge sys_clk);
    rd(8'h0c, 32'h36);
    chk({30'h0, matchOut2, matchOut1}, 32'h3);
    zReq <= 1'b1;
    @(posedge sys_clk);
    zReq <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rd(8'h0c, 32'h76);
    wr(8'h00, 32'hc);
    wr(8'h00, 32'h4);
    rd(8'h0c, 32'h36);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, matchOut2, matchOut1}, 32'h0);
    wr(8'h14, 32'h1f);
    // broken on purpose: both resets released too early
    wr(8'h00, 32'h3);
    wr(8'h00, 32'h0);
    rd(8'h14, 32'h18);
    chk({31'h0, irq}, 32'h0);
    rd(8'h0c, 32'h24);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h24);
    rd(8'h10, 32'hfffffffa);
    rd(8'h18, 32'h7);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    // byte lanes: only lane one lands, control ignores a write without lane zero
    avs_byteenable <= 4'h2;
    wr(8'h04, 32'h00001200);
    wr(8'h00, 32'h4);
    avs_byteenable <= 4'hf;
    rd(8'h04, 32'h00001205);
    rd(8'h00, 32'h0);
    test_done();
  end
endmodule : counter_point_compare_flags_tb_top
`default_nettype wire
